/* hdl/olodg_top.sv */
// Purpose: open-load diagnostics for five high-side outputs
// Assumes: comparator and pin inputs are asynchronous and pass two flops
// Notes: register reads answer one cycle after the strobe
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module olodg_top #(
   parameter int unsigned LED_WIN_P  = olodg_pkg::LED_WIN_CYC,
   parameter int unsigned OFF_TEST_P = olodg_pkg::OFF_TEST_CYC,
   parameter int unsigned LED_TAIL_P = olodg_pkg::LED_TAIL_CYC
) (
   // clock and reset
   input  wire logic                   CLK_I,
   input  wire logic                   RST_N_I,
   // register port
   input  wire logic [3:0]             ADDR_I,
   input  wire logic [15:0]            WDATA_I,
   input  wire logic                   WR_I,
   input  wire logic                   RD_I,
   output logic [15:0]                 RDATA_O,
   // serial chip select pin
   input  wire logic                   SERIAL_CHIP_SELECT_N_I,
   // channel command, comparators and faults
   input  wire logic [4:0]             ON_CMD_I,
   input  olodg_pkg::olodg_ch_in_t     CH_I,
   input  olodg_pkg::olodg_fault_t     FAULT_I,
   // channel drive
   output olodg_pkg::olodg_ch_out_t    CH_O,
   output logic                        FAULT_OFF_O
);
   import olodg_pkg::*;

   localparam logic [CNT_W-1:0] WIN_LIM   = CNT_W'(LED_WIN_P);
   localparam logic [CNT_W-1:0] OFF_LIM   = CNT_W'(OFF_TEST_P);
   localparam logic [CNT_W-1:0] TAIL_LIM  = CNT_W'(LED_TAIL_P);
   localparam logic [CNT_W-1:0] SHORT_LIM = CNT_W'(OLON_SHORT_CYC);
   localparam logic [7:0]       FDGL_LIM  = 8'(FAULT_DGL_CYC);

   typedef struct packed {
      olodg_ch_in_t               in1;
      olodg_ch_in_t               in2;
      olodg_fault_t               flt1;
      olodg_fault_t               flt2;
      logic                       cs1;
      logic                       cs2;
      logic                       cs_prev;
      logic [NCH-1:0]             cmd_prev;
      logic [NCH-1:0]             on_open_deglitch_select;
      logic [NCH-1:0]             led_detect_enable;
      logic                       led_detect_trigger;
      logic [NCH-1:0]             off_open_test_enable;
      logic [NCH-1:0]             off_run;
      logic [NCH-1:0]             led_active;
      logic [NCH-1:0]             trig_off;
      logic [NCH-1:0]             tail;
      logic [NCH-1:0][CNT_W-1:0]  on_cnt;
      logic [NCH-1:0][CNT_W-1:0]  led_cnt;
      logic [NCH-1:0][CNT_W-1:0]  off_cnt;
      logic [NCH-1:0]             on_flag;
      logic [NCH-1:0]             off_flag;
      logic [7:0]                 fdgl_cnt;
      logic                       fault_off;
      logic [15:0]                rdata;
      olodg_ch_out_t              ch_out;
   } olodg_state_t;

   olodg_state_t st_r;
   olodg_state_t st_nxt;
   logic         cs_rise;
   logic         fault_any;
   logic         wr_open;
   logic         wr_led;
   logic         trig_start;
   logic [NCH-1:0] rd_ch;
   logic [NCH-1:0] on_set;
   logic [NCH-1:0] on_clr;
   logic [NCH-1:0] off_set;
   logic [NCH-1:0] open_now;
   logic         global_flag;

   always_comb begin
      st_nxt     = st_r;
      on_set     = '0;
      off_set    = '0;
      st_nxt.in1 = CH_I;
      st_nxt.in2 = st_r.in1;
      st_nxt.flt1 = FAULT_I;
      st_nxt.flt2 = st_r.flt1;
      st_nxt.cs1 = SERIAL_CHIP_SELECT_N_I;
      st_nxt.cs2 = st_r.cs1;
      st_nxt.cs_prev = st_r.cs2;
      st_nxt.cmd_prev = ON_CMD_I;
      cs_rise    = st_r.cs2 & ~st_r.cs_prev;
      fault_any  = |st_r.flt2;
      wr_open    = WR_I && (ADDR_I == ADDR_OPEN_CTRL);
      wr_led     = WR_I && (ADDR_I == ADDR_LED_CTRL);
      trig_start = wr_led && WDATA_I[TRIG_BIT] && !st_r.led_detect_trigger;
      global_flag = |(st_r.on_flag | st_r.off_flag);

      // shutdown waits out the fault deglitch time
      if (fault_any) begin
         if (st_r.fdgl_cnt == FDGL_LIM) begin
            st_nxt.fault_off = 1'b1;
         end else begin
            st_nxt.fdgl_cnt = st_r.fdgl_cnt + 8'h01;
         end
      end else begin
         st_nxt.fdgl_cnt  = 8'h00;
         st_nxt.fault_off = 1'b0;
      end

      if (wr_open) begin
         st_nxt.on_open_deglitch_select = WDATA_I[4:0];
      end
      if (wr_led) begin
         st_nxt.led_detect_enable = WDATA_I[4:0];
         if (trig_start) begin
            st_nxt.led_detect_trigger = 1'b1;
         end
      end else if (st_r.led_detect_trigger && ~|(st_r.trig_off | st_r.tail)) begin
         st_nxt.led_detect_trigger = 1'b0;
      end

      for (int i = 0; i < NCH; i++) begin
         rd_ch[i]    = RD_I && (ADDR_I == ADDR_CH_BASE + 4'(i));
         open_now[i] = st_r.in2.low_current[i] & st_r.in2.out_high[i];

         // standard on-state filter, only while the output is high
         if (!st_r.in2.out_high[i] || !ON_CMD_I[i] || st_r.led_detect_enable[i]) begin
            st_nxt.on_cnt[i] = '0;
         end else if (st_r.in2.low_current[i]) begin
            if (st_r.on_cnt[i] == (st_r.on_open_deglitch_select[i] ? WIN_LIM : SHORT_LIM)) begin
               on_set[i] = 1'b1;
            end else begin
               st_nxt.on_cnt[i] = st_r.on_cnt[i] + 1'b1;
            end
         end else begin
            st_nxt.on_cnt[i] = '0;
         end

         // LED mode: judge the falling edge at each regular switch-off
         if (st_r.led_active[i]) begin
            st_nxt.led_cnt[i] = st_r.led_cnt[i] + 1'b1;
            if (ON_CMD_I[i]) begin
               st_nxt.led_active[i] = 1'b0;
               on_set[i] = st_r.in2.led_above[i];
            end else if (!st_r.in2.led_above[i]) begin
               st_nxt.led_active[i] = 1'b0;
            end else if (st_r.led_cnt[i] == WIN_LIM) begin
               st_nxt.led_active[i] = 1'b0;
               on_set[i] = 1'b1;
            end
         end else if (st_r.cmd_prev[i] && !ON_CMD_I[i] && st_r.led_detect_enable[i]) begin
            st_nxt.led_active[i] = 1'b1;
            st_nxt.led_cnt[i]    = '0;
         end

         // full-duty trigger: brief forced off, then a tail with the source on
         if (trig_start && ON_CMD_I[i] && WDATA_I[i]) begin
            st_nxt.trig_off[i] = 1'b1;
            st_nxt.led_cnt[i]  = '0;
         end else if (st_r.trig_off[i]) begin
            st_nxt.led_cnt[i] = st_r.led_cnt[i] + 1'b1;
            if (!st_r.in2.led_above[i] || st_r.led_cnt[i] == WIN_LIM) begin
               on_set[i] = st_r.in2.led_above[i];
               st_nxt.trig_off[i] = 1'b0;
               st_nxt.tail[i]     = 1'b1;
               st_nxt.led_cnt[i]  = '0;
            end
         end else if (st_r.tail[i]) begin
            st_nxt.led_cnt[i] = st_r.led_cnt[i] + 1'b1;
            if (st_r.led_cnt[i] == TAIL_LIM) begin
               st_nxt.tail[i] = 1'b0;
            end
         end

         // off-state test; a running test ignores writes to its enable
         if (wr_open && !st_r.off_run[i]) begin
            st_nxt.off_open_test_enable[i] = WDATA_I[OFFEN_LSB+i];
         end
         if (st_r.off_run[i]) begin
            st_nxt.off_cnt[i] = st_r.off_cnt[i] + 1'b1;
            if (fault_any) begin
               st_nxt.off_run[i] = 1'b0;
               st_nxt.off_open_test_enable[i] = 1'b0;
            end else if (st_r.in2.off_threshold[i]) begin
               st_nxt.off_run[i] = 1'b0;
               st_nxt.off_open_test_enable[i] = 1'b0;
            end else if (st_r.off_cnt[i] == OFF_LIM) begin
               st_nxt.off_run[i] = 1'b0;
               st_nxt.off_open_test_enable[i] = 1'b0;
               off_set[i] = 1'b1;
            end
         end else if (cs_rise && st_r.off_open_test_enable[i] && !fault_any) begin
            st_nxt.off_run[i] = 1'b1;
            st_nxt.off_cnt[i] = '0;
         end

         // latches: a new event beats a clearing read
         on_clr[i] = rd_ch[i] & (st_r.led_detect_enable[i] | ~open_now[i]);
         st_nxt.on_flag[i]  = on_set[i] | (st_r.on_flag[i] & ~on_clr[i]);
         st_nxt.off_flag[i] = off_set[i] | (st_r.off_flag[i] & ~rd_ch[i]);

         // open load never turns the output off; only trigger or fault do, and a running off test forces it on
         st_nxt.ch_out.drive[i] = ((ON_CMD_I[i] & ~st_nxt.trig_off[i]) | st_nxt.off_run[i])
                                  & ~st_nxt.fault_off;
         st_nxt.ch_out.led_test_current[i] = st_nxt.led_active[i] | st_nxt.trig_off[i]
                                             | st_nxt.tail[i];
         st_nxt.ch_out.off_test_current_threshold[i] = st_nxt.off_run[i];
      end

      // read data, sampled before this cycle's updates
      st_nxt.rdata = 16'h0000;
      if (RD_I) begin
         unique case (ADDR_I)
            ADDR_OPEN_CTRL: st_nxt.rdata = {3'b000, st_r.off_open_test_enable,
                                            3'b000, st_r.on_open_deglitch_select};
            ADDR_LED_CTRL:  st_nxt.rdata = {7'h00, st_r.led_detect_trigger,
                                            3'b000, st_r.led_detect_enable};
            ADDR_QUICK:     st_nxt.rdata = {QUICK_CODE, 3'b000, global_flag, 3'b000,
                                            st_r.on_flag | st_r.off_flag};
            default: begin
               for (int i = 0; i < NCH; i++) begin
                  if (rd_ch[i]) begin
                     st_nxt.rdata = {CH_CODE_BASE + 4'(i), 3'b000, global_flag, 6'h00,
                                     st_r.on_flag[i], st_r.off_flag[i]};
                  end
               end
            end
         endcase
      end
   end

   // all state but the chip-select copies clears at reset, so a test in flight is simply dropped
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_r         <= '0;
         // chip-select copies rest at the idle pin level, so release makes no false edge
         st_r.cs1     <= 1'b1;
         st_r.cs2     <= 1'b1;
         st_r.cs_prev <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign RDATA_O     = st_r.rdata;
   assign CH_O        = st_r.ch_out;
   assign FAULT_OFF_O = st_r.fault_off;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   quick_code_a: assert property (RD_I && ADDR_I == ADDR_QUICK |=>
      RDATA_O[15:12] == QUICK_CODE && RDATA_O[4:0] == $past(st_r.on_flag | st_r.off_flag))
      else $error("quick word layout wrong");
   off_start_a: assert property (cs_rise && st_r.off_open_test_enable[0] && !st_r.off_run[0]
      && !fault_any |=> st_r.off_run[0] ##1 CH_O.drive[0] || st_r.fault_off)
      else $error("off test did not start on chip-select rise");
   off_hold_a: assert property (st_r.off_run[0] && WR_I && ADDR_I == ADDR_OPEN_CTRL
      |=> st_r.off_open_test_enable[0] == $past(st_r.off_open_test_enable[0]))
      else $error("running off test was altered");
   off_end_a: assert property ($fell(st_r.off_run[0]) |-> !st_r.off_open_test_enable[0])
      else $error("off test ended with enable still set");
   off_flag_a: assert property ($rose(st_r.off_flag[0]) |-> $past(st_r.off_run[0])
      && !$past(st_r.in2.off_threshold[0]))
      else $error("off flag without timeout");
   fault_abort_a: assert property (fault_any && st_r.off_run[0] |=> !st_r.off_run[0])
      else $error("fault did not abort off test");
   dgl_clear_a: assert property (!st_r.in2.out_high[2] |=> st_r.on_cnt[2] == '0)
      else $error("deglitch filter not cleared");
   keep_on_a: assert property (ON_CMD_I[2] && !st_nxt.trig_off[2] && !st_nxt.fault_off
      |=> CH_O.drive[2])
      else $error("open load turned output off");
   src_limit_a: assert property (st_r.led_active[3] |-> st_r.led_cnt[3] <= WIN_LIM)
      else $error("led source beyond window");
   rd_clear_a: assert property (rd_ch[0] && !on_set[0] && !off_set[0] |=>
      !st_r.off_flag[0])
      else $error("read did not clear off flag");
   on_hold_a: assert property (rd_ch[2] && st_r.on_flag[2] && !st_r.led_detect_enable[2]
      && st_r.in2.low_current[2] && st_r.in2.out_high[2] |=> st_r.on_flag[2])
      else $error("on flag cleared while load still open");
   trig_force_a: assert property (st_r.trig_off[4] && !st_r.off_run[4]
      |-> !CH_O.drive[4] && CH_O.led_test_current[4])
      else $error("trigger did not force output off with source on");

   off_timeout_c: cover property ($rose(st_r.off_flag[0]));
   led_fault_c:   cover property (st_r.led_active[3] && on_set[3]);
   trig_done_c:   cover property ($fell(st_r.led_detect_trigger));
   fault_c:       cover property ($rose(st_r.fault_off));
endmodule : olodg_top

/* hdl/olodg_pkg.sv */
// Purpose: constants and carrier types for the five-channel open-load diagnostics
// Assumes: 50 MHz block clock, analog comparators outside this block
package olodg_pkg;
   localparam int NCH   = 5;
   localparam int CNT_W = 17;

   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned OLON_SHORT_NS  = 64000;
   localparam int unsigned LED_WIN_NS     = 2000000;
   localparam int unsigned OFF_TEST_NS    = 1200000;
   localparam int unsigned LED_TAIL_NS    = 100000;
   localparam int unsigned FAULT_DGL_NS   = 3300;
   localparam int unsigned OLON_SHORT_CYC = OLON_SHORT_NS / CLK_PERIOD_NS;
   localparam int unsigned LED_WIN_CYC    = LED_WIN_NS / CLK_PERIOD_NS;
   localparam int unsigned OFF_TEST_CYC   = OFF_TEST_NS / CLK_PERIOD_NS;
   localparam int unsigned LED_TAIL_CYC   = LED_TAIL_NS / CLK_PERIOD_NS;
   localparam int unsigned FAULT_DGL_CYC  = FAULT_DGL_NS / CLK_PERIOD_NS;

   localparam logic [3:0] ADDR_OPEN_CTRL = 4'h0;
   localparam logic [3:0] ADDR_LED_CTRL  = 4'h1;
   localparam logic [3:0] ADDR_QUICK     = 4'h2;
   localparam logic [3:0] ADDR_CH_BASE   = 4'h3;

   localparam logic [3:0] QUICK_CODE   = 4'h1;
   localparam logic [3:0] CH_CODE_BASE = 4'h2;
   localparam int         GLOBAL_FLAG_BIT = 8;
   localparam int         ON_BIT       = 1;
   localparam int         OFF_BIT      = 0;
   localparam int         TRIG_BIT     = 8;
   localparam int         OFFEN_LSB    = 8;
   localparam logic [4:0] CTRL_RESET   = 5'h00;

   typedef struct packed {
      logic [NCH-1:0] out_high;
      logic [NCH-1:0] low_current;
      logic [NCH-1:0] led_above;
      logic [NCH-1:0] off_threshold;
   } olodg_ch_in_t;

   typedef struct packed {
      logic [NCH-1:0] drive;
      logic [NCH-1:0] led_test_current;
      logic [NCH-1:0] off_test_current_threshold;
   } olodg_ch_out_t;

   typedef struct packed {
      logic overtemp_shutdown;
      logic undervoltage;
      logic charge_pump_fault;
   } olodg_fault_t;
endpackage : olodg_pkg

/* dv/olodg_load_model.sv */
// Purpose: far-side power stage and load model for the open-load diagnostics
// Assumes: each channel load is either present or open, chosen by open_mask_i
// Notes: comparators answer at once; the block's own sync flops add the delay
`timescale 1ns/1ns
module olodg_load_model (
   // drive from the block
   input  wire olodg_pkg::olodg_ch_out_t ch_i,
   // load selection
   input  wire logic [4:0]               open_mask_i,
   // comparator feedback
   output olodg_pkg::olodg_ch_in_t       ch_o
);
   import olodg_pkg::*;
   assign ch_o.out_high    = ch_i.drive;
   // an open load leaves the on-state current under the threshold
   assign ch_o.low_current = ch_i.drive & open_mask_i;
   // an open led string keeps the pin near battery while the test source runs
   assign ch_o.led_above   = ch_i.drive | (ch_i.led_test_current & open_mask_i);
   // a present load pulls the fixed threshold current at once
   assign ch_o.off_threshold = ch_i.drive & ch_i.off_test_current_threshold & ~open_mask_i;
endmodule : olodg_load_model

/* dv/open_load_diagnostics_test.sv */
// Purpose: self-checking bench for the open-load diagnostics block
// Assumes: shortened windows set by parameter, load model on the far side
// Notes: reads are checked in the single cycle the data stands
`timescale 1ns/1ns
module open_load_diagnostics_test;
   import olodg_pkg::*;
   localparam int unsigned OFF_P = 30;
   logic          clk, rst_n, wr, rd, cs_n, fault_off;
   logic [3:0]    addr;
   logic [15:0]   wdata, rdata;
   logic [4:0]    on_cmd, open_mask;
   olodg_ch_in_t  ch_in;
   olodg_ch_out_t ch_out;
   olodg_fault_t  fault;
   int            num_errors, check_count;

   olodg_top #(.LED_WIN_P(50), .OFF_TEST_P(OFF_P), .LED_TAIL_P(10)) u_olodg_top (
      .CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .SERIAL_CHIP_SELECT_N_I(cs_n), .ON_CMD_I(on_cmd),
      .CH_I(ch_in), .FAULT_I(fault), .CH_O(ch_out), .FAULT_OFF_O(fault_off));
   olodg_load_model u_olodg_load_model (.ch_i(ch_out), .open_mask_i(open_mask), .ch_o(ch_in));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(negedge clk);
      chk(rdata, exp);
   endtask : rd_reg

   // one serial frame; its closing rise of chip select starts the off tests
   task automatic frame();
      @(posedge clk);
      cs_n <= 1'b0;
      repeat (8) @(posedge clk);
      cs_n <= 1'b1;
   endtask : frame

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   initial begin
      #(20 * 40000);
      num_errors++;
      close_out();
   end

   initial begin
      {rst_n, wr, rd, addr, wdata, on_cmd, open_mask, fault} = '0;
      cs_n = 1'b1;
      num_errors = 0;
      check_count = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(ADDR_OPEN_CTRL, 16'h0000);
      rd_reg(ADDR_LED_CTRL, 16'h0000);
      rd_reg(ADDR_QUICK, 16'h1000);
      wr_reg(4'hc, 16'hffff);
      rd_reg(4'hc, 16'h0000);
      $display("test reset done");

      // ch1 open, ch2 loaded: one times out, one ends early
      open_mask <= 5'h01;
      wr_reg(ADDR_OPEN_CTRL, 16'h0300);
      frame();
      repeat (12) @(posedge clk);
      chk({11'h0, ch_out.off_test_current_threshold}, 16'h0001);
      chk({11'h0, ch_out.drive}, 16'h0001);
      wr_reg(ADDR_OPEN_CTRL, 16'h0000);
      rd_reg(ADDR_OPEN_CTRL, 16'h0100);
      repeat (OFF_P + 10) @(posedge clk);
      chk({11'h0, ch_out.drive}, 16'h0000);
      rd_reg(ADDR_OPEN_CTRL, 16'h0000);
      rd_reg(ADDR_QUICK, 16'h1101);
      rd_reg(ADDR_CH_BASE, 16'h2101);
      rd_reg(ADDR_CH_BASE, 16'h2000);
      $display("test off state done");

      // ch3 open in on state; a short on time must not reach the flag
      open_mask <= 5'h04;
      on_cmd    <= 5'h04;
      repeat (3000) @(posedge clk);
      on_cmd <= 5'h00;
      repeat (5) @(posedge clk);
      on_cmd <= 5'h04;
      repeat (3000) @(posedge clk);
      rd_reg(ADDR_QUICK, 16'h1000);
      repeat (300) @(posedge clk);
      chk({11'h0, ch_out.drive}, 16'h0004);
      rd_reg(ADDR_QUICK, 16'h1104);
      rd_reg(ADDR_CH_BASE + 4'h2, 16'h4102);
      rd_reg(ADDR_CH_BASE + 4'h2, 16'h4102);
      open_mask <= 5'h00;
      repeat (5) @(posedge clk);
      rd_reg(ADDR_CH_BASE + 4'h2, 16'h4102);
      rd_reg(ADDR_CH_BASE + 4'h2, 16'h4000);
      on_cmd <= 5'h00;
      // slow deglitch on ch3: the flag needs the long window
      wr_reg(ADDR_OPEN_CTRL, 16'h0004);
      rd_reg(ADDR_OPEN_CTRL, 16'h0004);
      open_mask <= 5'h04;
      on_cmd    <= 5'h04;
      repeat (40) @(posedge clk);
      rd_reg(ADDR_QUICK, 16'h1000);
      repeat (30) @(posedge clk);
      rd_reg(ADDR_QUICK, 16'h1104);
      on_cmd    <= 5'h00;
      open_mask <= 5'h00;
      repeat (5) @(posedge clk);
      rd_reg(ADDR_CH_BASE + 4'h2, 16'h4102);
      rd_reg(ADDR_CH_BASE + 4'h2, 16'h4000);
      $display("test on state done");

      // ch4 led mode with an open string: fault after the off window
      wr_reg(ADDR_LED_CTRL, 16'h0008);
      open_mask <= 5'h08;
      on_cmd    <= 5'h08;
      repeat (20) @(posedge clk);
      on_cmd <= 5'h00;
      repeat (6) @(posedge clk);
      chk({11'h0, ch_out.led_test_current}, 16'h0008);
      repeat (60) @(posedge clk);
      chk({11'h0, ch_out.led_test_current}, 16'h0000);
      rd_reg(ADDR_QUICK, 16'h1108);
      rd_reg(ADDR_CH_BASE + 4'h3, 16'h5102);
      rd_reg(ADDR_CH_BASE + 4'h3, 16'h5000);
      wr_reg(ADDR_LED_CTRL, 16'h0000);
      // full duty on ch5, open string: trigger forces a detection
      wr_reg(ADDR_LED_CTRL, 16'h0010);
      open_mask <= 5'h10;
      on_cmd    <= 5'h10;
      repeat (10) @(posedge clk);
      wr_reg(ADDR_LED_CTRL, 16'h0110);
      repeat (20) @(posedge clk);
      chk({11'h0, ch_out.drive}, 16'h0000);
      chk({11'h0, ch_out.led_test_current}, 16'h0010);
      rd_reg(ADDR_LED_CTRL, 16'h0110);
      repeat (60) @(posedge clk);
      chk({11'h0, ch_out.drive}, 16'h0010);
      chk({11'h0, ch_out.led_test_current}, 16'h0000);
      rd_reg(ADDR_LED_CTRL, 16'h0010);
      rd_reg(ADDR_QUICK, 16'h1110);
      rd_reg(ADDR_CH_BASE + 4'h4, 16'h6102);
      rd_reg(ADDR_CH_BASE + 4'h4, 16'h6000);
      wr_reg(ADDR_LED_CTRL, 16'h0000);
      on_cmd <= 5'h00;
      $display("test led done");

      // undervoltage in mid-test aborts it without an open flag
      open_mask <= 5'h01;
      wr_reg(ADDR_OPEN_CTRL, 16'h0100);
      frame();
      repeat (10) @(posedge clk);
      fault <= 3'b010;
      repeat (200) @(posedge clk);
      chk({11'h0, ch_out.off_test_current_threshold}, 16'h0000);
      chk({11'h0, ch_out.drive}, 16'h0000);
      chk({15'h0, fault_off}, 16'h0001);
      rd_reg(ADDR_QUICK, 16'h1000);
      fault <= 3'b000;
      $display("test fault done");

      // reset while an off test runs drops it with nothing latched
      wr_reg(ADDR_OPEN_CTRL, 16'h0100);
      frame();
      repeat (10) @(posedge clk);
      chk({15'h0, fault_off}, 16'h0000);
      chk({11'h0, ch_out.off_test_current_threshold}, 16'h0001);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      chk({11'h0, ch_out.off_test_current_threshold}, 16'h0000);
      rd_reg(ADDR_OPEN_CTRL, 16'h0000);
      rd_reg(ADDR_QUICK, 16'h1000);
      $display("test reset in flight done");
      close_out();
   end
endmodule : open_load_diagnostics_test
